// >>> tc16_timer_ctrl.sv
// Timer control register, prescaler and 16-bit counter with Wishbone slave
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tc16_timer_ctrl
  import tc16_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Wishbone classic slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Device context
  input wire logic CYCLE_TICK_I,
  input wire logic IDLE_MODE_I,
  input wire logic PAIR_WIDE_MODE_I,
  input wire logic GATE_PIN_I,
  input wire logic EXTERNAL_TIMER_CLOCK_PIN_I,
  // Timer state
  output logic [WIDTH-1:0] COUNT_O,
  output logic RUNNING_O
);
  import tc16_pkg::*;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  logic [15:0] ctrl_ff;

  logic [WIDTH-1:0] count_ff;

  logic [WIDTH-1:0] nxt_count;

  logic [7:0] pre_ff;

  logic [7:0] nxt_pre;

  logic ext_d_ff;

  logic ack_ff;

  logic [31:0] dat_ff;

  logic [31:0] nxt_dat;

  logic running_ff;

  // ----------------------------------------
  // Decoded terms
  // ----------------------------------------
  logic req;

  logic rd_req;

  logic wr_ctrl;

  logic wr_count;

  logic src_is_ext;

  logic gate_bit;

  logic run_bit;

  logic idle_stop_bit;

  logic ext_rise;

  logic src_tick;

  logic gate_ok;

  logic idle_halt;

  logic active;

  logic pre_wrap;

  logic pre_tick;

  logic [1:0] ps_code;

  logic [7:0] tc;

  // ----------------------------------------
  // Prescale decode
  // ----------------------------------------
  function automatic logic [7:0] ps_tc(input logic [1:0] code);
    case (code)
      TC16_PS_DIV8:
      begin
        ps_tc = TC16_TC_DIV8;
      end
      TC16_PS_DIV64:
      begin
        ps_tc = TC16_TC_DIV64;
      end
      TC16_PS_DIV256:
      begin
        ps_tc = TC16_TC_DIV256;
      end
      default:
      begin
        ps_tc = 8'h00;
      end
    endcase
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_is(input logic [3:0] adr, input logic [3:0] slot);
    addr_is = (adr == slot);
  endfunction

  // ----------------------------------------
  // Read word assembly
  // ----------------------------------------
  // Unmapped offsets answer zero rather than an error
  function automatic logic [31:0] rd_word(
    input logic [3:0] adr,
    input logic [15:0] ctrl,
    input logic [WIDTH-1:0] count,
    input logic pair,
    input logic act
  );
    rd_word = 32'h0000_0000;
    if (addr_is(adr, TC16_ADDR_CONTROL))
    begin
      rd_word = {16'h0000, ctrl & TC16_CTRL_MASK};
    end
    else if (addr_is(adr, TC16_ADDR_COUNT))
    begin
      rd_word = {{(32-WIDTH){1'b0}}, count};
    end
    else if (addr_is(adr, TC16_ADDR_STATUS))
    begin
      rd_word = {30'h0000_0000, pair, act};
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Ack gates the request so a held cycle is taken once
  assign req = CYC_I & STB_I & ~ack_ff;

  assign rd_req = req & ~WE_I;

  assign wr_ctrl = req & WE_I & addr_is(ADR_I, TC16_ADDR_CONTROL);

  assign wr_count = req & WE_I & addr_is(ADR_I, TC16_ADDR_COUNT);

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  assign run_bit = ctrl_ff[TC16_BIT_RUN];

  assign idle_stop_bit = ctrl_ff[TC16_BIT_IDLE_STOP];

  assign gate_bit = ctrl_ff[TC16_BIT_GATE];

  assign ps_code = ctrl_ff[TC16_BIT_PS_HI:TC16_BIT_PS_LO];

  assign src_is_ext = ctrl_ff[TC16_BIT_SRC];

  // ----------------------------------------
  // Tick selection
  // ----------------------------------------
  // Pin sampled on the system clock; pulses shorter than a cycle are lost
  assign ext_rise = EXTERNAL_TIMER_CLOCK_PIN_I & ~ext_d_ff;

  assign src_tick = src_is_ext ? ext_rise : CYCLE_TICK_I;

  assign gate_ok = src_is_ext | ~gate_bit | GATE_PIN_I;

  assign idle_halt = IDLE_MODE_I & idle_stop_bit;

  // Paired mode hands the counter to the partner's control
  assign active = run_bit & ~PAIR_WIDE_MODE_I & ~idle_halt;

  assign tc = ps_tc(ps_code);

  assign pre_wrap = (pre_ff == tc);

  assign pre_tick = active & gate_ok & src_tick & pre_wrap;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ctrl_ff <= TC16_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      if (SEL_I[0])
      begin
        ctrl_ff[7:0] <= DAT_I[7:0] & TC16_CTRL_MASK[7:0];
      end
      if (SEL_I[1])
      begin
        ctrl_ff[15:8] <= DAT_I[15:8] & TC16_CTRL_MASK[15:8];
      end
    end
  end

  // ----------------------------------------
  // Edge sampler
  // ----------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ext_d_ff <= 1'b0;
    end
    else
    begin
      ext_d_ff <= EXTERNAL_TIMER_CLOCK_PIN_I;
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Writing control restarts the division so a new ratio starts clean
  always_comb
  begin
    nxt_pre = pre_ff;
    if (wr_ctrl | ~active)
    begin
      nxt_pre = 8'h00;
    end
    else if (gate_ok & src_tick)
    begin
      if (pre_wrap)
      begin
        nxt_pre = 8'h00;
      end
      else
      begin
        nxt_pre = pre_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pre_ff <= 8'h00;
    end
    else
    begin
      pre_ff <= nxt_pre;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // A software write wins over a tick in the same cycle
  always_comb
  begin
    nxt_count = count_ff;
    if (wr_count)
    begin
      nxt_count = DAT_I[WIDTH-1:0];
    end
    else if (pre_tick)
    begin
      nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      count_ff <= '0;
    end
    else
    begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------
  // Run indication
  // ----------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      running_ff <= 1'b0;
    end
    else
    begin
      running_ff <= active;
    end
  end

  // ----------------------------------------
  // Bus acknowledge
  // ----------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data holds until the next read so a slow master still sees it
  always_comb
  begin
    nxt_dat = dat_ff;
    if (rd_req)
    begin
      nxt_dat = rd_word(ADR_I, ctrl_ff, count_ff, PAIR_WIDE_MODE_I, active);
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      dat_ff <= nxt_dat;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign DAT_O = dat_ff;

  assign ACK_O = ack_ff;

  assign COUNT_O = count_ff;

  assign RUNNING_O = running_ff;
endmodule

// >>> tc16_pkg.sv
// Constants, field layout and register map of the 16-bit timer control block
// What this block does
// - Idle-stop bit 13 halts timer in Idle
// - Gate bit ignored when external clock selected
// - Bit 1 selects external pin clock
// - Unimplemented bits read zero, writes ignored
// - Paired mode makes run/gate/prescale/source inert
// - All implemented control bits reset to zero
package tc16_pkg;
  // ----------------------------------------
  // Register map (word addresses, byte offsets)
  // ----------------------------------------
  localparam logic [3:0] TC16_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] TC16_ADDR_COUNT = 4'h4;
  localparam logic [3:0] TC16_ADDR_STATUS = 4'h8;
  // ----------------------------------------
  // Control field layout
  // ----------------------------------------
  localparam int TC16_BIT_RUN = 15;
  localparam int TC16_BIT_IDLE_STOP = 13;
  localparam int TC16_BIT_GATE = 6;
  localparam int TC16_BIT_PS_HI = 5;
  localparam int TC16_BIT_PS_LO = 4;
  localparam int TC16_BIT_SRC = 1;
  localparam logic [15:0] TC16_CTRL_MASK = 16'hA072;
  localparam logic [15:0] TC16_CTRL_RESET = 16'h0000;
  // ----------------------------------------
  // Prescale codes and terminal counts
  // ----------------------------------------
  localparam logic [1:0] TC16_PS_DIV1 = 2'h0;
  localparam logic [1:0] TC16_PS_DIV8 = 2'h1;
  localparam logic [1:0] TC16_PS_DIV64 = 2'h2;
  localparam logic [1:0] TC16_PS_DIV256 = 2'h3;
  localparam logic [7:0] TC16_TC_DIV8 = 8'h07;
  localparam logic [7:0] TC16_TC_DIV64 = 8'h3F;
  localparam logic [7:0] TC16_TC_DIV256 = 8'hFF;
endpackage

// >>> tc16_timer_ctrl_assertions.sv
// Port checker for the timer control block
`timescale 1ns/1ps
module tc16_timer_ctrl_chk #(parameter int WIDTH = 16)
(
  // Clock, reset and bus
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // Timer
  input wire logic PAIR_WIDE_MODE_I,
  input wire logic [WIDTH-1:0] COUNT_O,
  input wire logic RUNNING_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  logic req;
  assign req = CYC_I && STB_I;
  ack_once_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  ack_latency_a: assert property (req && !ACK_O |=> ACK_O) else $error("ack late");
  ack_cause_a: assert property (ACK_O |-> $past(req)) else $error("stray ack");
  ctrl_zero_a: assert property (ACK_O && $past(!WE_I && ADR_I == 4'h0) |-> (DAT_O & 32'hFFFF5F8D) == 32'h0)
    else $error("unused bit set");
  unmapped_zero_a: assert property (ACK_O && $past(!WE_I && ADR_I == 4'hC) |-> DAT_O == 32'h0)
    else $error("unmapped read");
  pair_hold_a: assert property ($past(PAIR_WIDE_MODE_I) && !$past(req && WE_I) |-> $stable(COUNT_O))
    else $error("count in pair");
  run_pair_a: assert property ($past(PAIR_WIDE_MODE_I) |-> !RUNNING_O) else $error("runs in pair");
  count_step_a: assert property (!$past(req && WE_I) |-> COUNT_O == $past(COUNT_O)
    || COUNT_O == $past(COUNT_O) + 16'h1) else $error("count jump");
  cover property (ACK_O && $past(WE_I));
  cover property ($rose(RUNNING_O));
  cover property (COUNT_O == 16'h3);
endmodule
bind tc16_timer_ctrl tc16_timer_ctrl_chk #(.WIDTH(WIDTH)) tc16_timer_ctrl_chk_inst (.MCLK_I, .RST_I, .CYC_I,
  .STB_I, .WE_I, .ADR_I, .DAT_O, .ACK_O, .PAIR_WIDE_MODE_I, .COUNT_O, .RUNNING_O);

// >>> tc16_ext_clk.sv
// External clock source on the timer clock pin
`timescale 1ns/1ps
module tc16_ext_clk #(parameter int HALF = 2)
(
  input wire logic clk_i,
  input wire logic en_i,
  output logic pin_o
);
  int cnt = 0;
  // Stands low between bursts
  always @(posedge clk_i)
  begin
    cnt <= en_i && cnt < 2 * HALF - 1 ? cnt + 1 : 0;
    pin_o <= en_i && cnt >= HALF;
  end
endmodule

// >>> test_timer_control_16bit.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module test_timer_control_16bit;
  import tc16_pkg::*;
  logic MCLK_I = 0, RST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0, ACK_O, RUNNING_O, en = 0;
  logic CYCLE_TICK_I = 0, IDLE_MODE_I = 0, PAIR_WIDE_MODE_I = 0, GATE_PIN_I = 0, EXTERNAL_TIMER_CLOCK_PIN_I;
  logic [3:0] ADR_I = 4'h0, SEL_I = 4'h3;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  logic [15:0] COUNT_O;
  int fail_count = 0, num_checks = 0, edges = 0, dv[4] = '{1, 8, 64, 256};
  logic [31:0] rows[3] = '{32'hFFFF_A072, 32'h5F8D_0000, 32'h0032_0032};
  always #2 MCLK_I = ~MCLK_I;
  always @(posedge EXTERNAL_TIMER_CLOCK_PIN_I) edges++;
  tc16_ext_clk tc16_ext_clk_inst (.clk_i(MCLK_I), .en_i(en), .pin_o(EXTERNAL_TIMER_CLOCK_PIN_I));
  tc16_timer_ctrl tc16_timer_ctrl_inst (.MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CYCLE_TICK_I(CYCLE_TICK_I),
    .IDLE_MODE_I(IDLE_MODE_I), .PAIR_WIDE_MODE_I(PAIR_WIDE_MODE_I), .GATE_PIN_I(GATE_PIN_I),
    .EXTERNAL_TIMER_CLOCK_PIN_I(EXTERNAL_TIMER_CLOCK_PIN_I), .COUNT_O(COUNT_O), .RUNNING_O(RUNNING_O));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, w, a, d};
    do
      @(posedge MCLK_I);
    while (ACK_O !== 1'b1 && n++ < 20);
    chk(ACK_O, 1);
    q = DAT_O;
    {CYC_I, STB_I} <= 2'b00;
    @(posedge MCLK_I);
  endtask
  // Ticks are held off during bus cycles so counts are exact
  task automatic run(input logic [15:0] c, input int k, input logic e);
    wb(1, TC16_ADDR_COUNT, 0);
    wb(1, TC16_ADDR_CONTROL, {16'h0, c});
    edges = 0;
    {CYCLE_TICK_I, en} <= {!e, e};
    repeat (k) @(posedge MCLK_I);
    {CYCLE_TICK_I, en} <= 2'b00;
    repeat (8) @(posedge MCLK_I);
    chk(RUNNING_O, c[15] && !PAIR_WIDE_MODE_I && !(IDLE_MODE_I && c[13]));
    wb(1, TC16_ADDR_CONTROL, 0);
    wb(0, TC16_ADDR_COUNT, 0);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
  initial
  begin
    repeat (2) @(posedge MCLK_I);
    RST_I <= 0;
    wb(0, TC16_ADDR_CONTROL, 0);
    chk(q, 0);
    foreach (rows[i])
    begin
      wb(1, TC16_ADDR_CONTROL, {16'h0, rows[i][31:16]});
      wb(0, TC16_ADDR_CONTROL, 0);
      chk(q, {16'h0, rows[i][15:0]});
    end
    for (int p = 0; p < 4; p++)
    begin
      run({10'h200, p[1:0], 4'h0}, 3 * dv[p], 0);
      chk(q, 3);
      chk(COUNT_O, 3);
    end
    run(16'h8040, 8, 0);
    chk(q, 0);
    GATE_PIN_I <= 1;
    run(16'h8040, 8, 0);
    chk(q, 8);
    GATE_PIN_I <= 0;
    run(16'h8042, 40, 1);
    chk(q, edges);
    IDLE_MODE_I <= 1;
    run(16'hA000, 4, 0);
    chk(q, 0);
    run(16'h8000, 4, 0);
    chk(q, 4);
    {IDLE_MODE_I, PAIR_WIDE_MODE_I} <= 2'b01;
    run(16'h8000, 4, 0);
    chk(q, 0);
    wb(0, TC16_ADDR_STATUS, 0);
    chk(q, 32'h2);
    wb(0, 4'hC, 0);
    chk(q, 0);
    PAIR_WIDE_MODE_I <= 0;
    wb(1, TC16_ADDR_COUNT, 5);
    wb(1, TC16_ADDR_CONTROL, 32'hA072);
    RST_I <= 1;
    @(posedge MCLK_I);
    RST_I <= 0;
    chk(COUNT_O, 0);
    wb(0, TC16_ADDR_CONTROL, 0);
    chk(q, 0);
    chk(RUNNING_O, 0);
    print_verdict();
  end
endmodule
